/* File: bca_config_regs.sv */
// bytecode accelerator configuration registers behind coprocessor transfers
`timescale 1ns/1ps
`default_nettype none

module bca_config_regs (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// coprocessor transfer request
	input wire logic cp_valid,
	input wire logic cp_write,
	input wire logic cp_priv,
	input wire logic [2:0] cp_opc1,
	input wire logic [3:0] cp_crn,
	input wire logic [3:0] cp_crm,
	input wire logic [2:0] cp_opc2,
	input wire logic [31:0] cp_wdata,
	// coprocessor transfer answer
	output logic cp_ack,
	output logic cp_undef,
	output logic [31:0] cp_rdata,
	// state-change requests from the core
	input wire logic branch_to_bytecode,
	input wire logic psw_bytecode_set,
	// state-change outcomes
	output logic enter_bytecode,
	output logic plain_branch_exchange,
	output logic accel_disabled_exc,
	// configuration seen by the accelerator
	output logic field_index_width,
	output logic static_ref_pointer_mode,
	output logic accel_enable,
	output logic [4:0] bounds_bit_position,
	output logic [4:0] array_descriptor_offset_signed,
	output logic signed [4:0] desc_offset_words,
	output logic [3:0] array_data_word_offset,
	output logic [3:0] static_value_offset,
	output logic [3:0] object_field_offset,
	// bytecode translation lookup
	input wire logic lookup_valid,
	input wire logic [7:0] lookup_bytecode,
	output logic lookup_done,
	output logic lookup_hit,
	output logic [3:0] lookup_op
);
	import bca_pkg::*;

	typedef struct packed {
		logic [31:0] main_cfg;
		logic [31:0] params;
		logic [31:0] xlat;
		logic [4:0] desc_off;
		logic ack;
		logic undef;
		logic [31:0] rdata;
		logic enter;
		logic plain;
		logic dis_exc;
		logic lk_done;
		logic lk_hit;
		logic [3:0] lk_op;
	} bca_regs_s;

	bca_regs_s st;
	bca_regs_s next_st;
	logic hit_main;
	logic hit_param;
	logic hit_xlat;
	logic op_ok;
	logic tbl_wr;
	logic tbl_hit;
	logic [3:0] tbl_op;
	logic [4:0] mag;

	// ****************************************************************
	// register decode
	// ****************************************************************

	// selector match for each register
	assign hit_main = cp_sel(cp_opc1, cp_crn, cp_crm, cp_opc2, CRN_MAIN); // RL5
	assign hit_param = cp_sel(cp_opc1, cp_crn, cp_crm, cp_opc2, CRN_PARAM); // RL12
	assign hit_xlat = cp_sel(cp_opc1, cp_crn, cp_crm, cp_opc2, CRN_XLAT);
	// an entry is accepted only with a legal operation and configurable code
	assign op_ok = (cp_wdata[XLAT_OP_LSB +: 4] <= OP_MAX) && code_ok(cp_wdata[XLAT_CODE_LSB +: 6]); // RL15
	assign tbl_wr = cp_valid && cp_priv && cp_write && hit_xlat && op_ok; // RL13
	assign mag = {1'b0, cp_wdata[DESC_OFF_LSB +: 4]};

	bca_xlat_table u_table (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.wr_en(tbl_wr),
		.wr_code(cp_wdata[XLAT_CODE_LSB +: 6]),
		.wr_op(cp_wdata[XLAT_OP_LSB +: 4]),
		.rd_bytecode(lookup_bytecode),
		.rd_hit(tbl_hit),
		.rd_op(tbl_op)
	);

	// ****************************************************************
	// next state
	// ****************************************************************

	// answer flags and events are one-cycle pulses; stored words keep reserved bits zero
	always_comb begin
		next_st = st;
		next_st.ack = 1'b0;
		next_st.undef = 1'b0;
		next_st.enter = 1'b0;
		next_st.plain = 1'b0;
		next_st.dis_exc = 1'b0;
		next_st.lk_done = lookup_valid;
		next_st.lk_hit = lookup_valid && tbl_hit; // RL13
		next_st.lk_op = tbl_op;
		if (cp_valid) begin
			if (!cp_priv || !(hit_main || hit_param || hit_xlat)) begin
				next_st.undef = 1'b1; // RL6
			end else if (cp_write && hit_xlat && !op_ok) begin
				next_st.undef = 1'b1; // RL15
			end else begin
				next_st.ack = 1'b1;
				if (cp_write) begin
					if (hit_main) begin
						next_st.main_cfg = cp_wdata & MAIN_MASK; // RL1 RL2 RL16
					end else if (hit_param) begin
						next_st.params = cp_wdata & PARAM_MASK; // RL16
						// sign-magnitude to two's complement, done once at write time
						next_st.desc_off = cp_wdata[DESC_OFF_SIGN_BIT] ? 5'(-mag) : mag; // RL8
					end else begin
						next_st.xlat = cp_wdata & XLAT_MASK; // RL14 RL16
					end
				end else begin
					next_st.rdata = hit_main ? st.main_cfg : (hit_param ? st.params : st.xlat);
				end
			end
		end
		// a disabled unit lets the branch fall back and traps the flag write
		if (branch_to_bytecode) begin
			if (st.main_cfg[ENABLE_BIT]) begin
				next_st.enter = 1'b1; // RL4
			end else begin
				next_st.plain = 1'b1; // RL3
			end
		end
		if (psw_bytecode_set) begin
			if (st.main_cfg[ENABLE_BIT]) begin
				next_st.enter = 1'b1; // RL4
			end else begin
				next_st.dis_exc = 1'b1; // RL3
			end
		end
	end

	// synchronous active-low reset
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			st <= '0;
			st.main_cfg <= MAIN_RESET;
			st.params <= PARAM_RESET;
			st.xlat <= XLAT_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************

	// every output is a flip-flop bit of the state
	assign cp_ack = st.ack;
	assign cp_undef = st.undef;
	assign cp_rdata = st.rdata;
	assign enter_bytecode = st.enter;
	assign plain_branch_exchange = st.plain;
	assign accel_disabled_exc = st.dis_exc;
	assign field_index_width = st.main_cfg[IDX_WIDTH_BIT]; // RL1
	assign static_ref_pointer_mode = st.main_cfg[STATIC_PTR_BIT]; // RL2
	assign accel_enable = st.main_cfg[ENABLE_BIT];
	assign bounds_bit_position = st.params[BOUNDS_POS_LSB +: 5]; // RL7
	assign array_descriptor_offset_signed = st.params[DESC_OFF_LSB +: 5]; // RL8
	assign desc_offset_words = st.desc_off;
	assign array_data_word_offset = st.params[DATA_OFF_LSB +: 4]; // RL9
	assign static_value_offset = st.params[STATIC_OFF_LSB +: 4]; // RL10
	assign object_field_offset = st.params[FIELD_OFF_LSB +: 4]; // RL11
	assign lookup_done = st.lk_done;
	assign lookup_hit = st.lk_hit;
	assign lookup_op = st.lk_op;

	// ****************************************************************
	// assertions
	// ****************************************************************

	property p_idx_width;
		@(posedge ref_clk) disable iff (!rstn)
		cp_valid && cp_priv && cp_write && hit_main |=> field_index_width == $past(cp_wdata[IDX_WIDTH_BIT]);
	endproperty
	a_idx_width: assert property (p_idx_width) else $error("index width bit not taken"); // RL1

	property p_static_mode;
		@(posedge ref_clk) disable iff (!rstn)
		cp_valid && cp_priv && cp_write && hit_main |=> static_ref_pointer_mode == $past(cp_wdata[STATIC_PTR_BIT]);
	endproperty
	a_static_mode: assert property (p_static_mode) else $error("static mode bit not taken"); // RL2

	property p_disabled;
		@(posedge ref_clk) disable iff (!rstn)
		!accel_enable && psw_bytecode_set && branch_to_bytecode |=>
			accel_disabled_exc && plain_branch_exchange && !enter_bytecode;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled unit entered bytecode state"); // RL3

	property p_enabled;
		@(posedge ref_clk) disable iff (!rstn)
		accel_enable && (branch_to_bytecode || psw_bytecode_set) |=>
			enter_bytecode && !accel_disabled_exc && !plain_branch_exchange;
	endproperty
	a_enabled: assert property (p_enabled) else $error("enabled unit did not enter bytecode state"); // RL4

	property p_main_read;
		@(posedge ref_clk) disable iff (!rstn)
		cp_valid && cp_priv && !cp_write && hit_main |=>
			cp_ack && cp_rdata == {4'h0, field_index_width, static_ref_pointer_mode, 25'h000_0000, accel_enable};
	endproperty
	a_main_read: assert property (p_main_read) else $error("main word read mismatch"); // RL5

	property p_unpriv;
		@(posedge ref_clk) disable iff (!rstn)
		cp_valid && !cp_priv ##1 1'b1 |-> cp_undef && !cp_ack && $stable(accel_enable);
	endproperty
	a_unpriv: assert property (p_unpriv) else $error("unprivileged access not refused"); // RL6

	property p_desc_offset;
		@(posedge ref_clk) disable iff (!rstn)
		cp_valid && cp_priv && cp_write && hit_param |=> (desc_offset_words < 0 ? -desc_offset_words :
			desc_offset_words) == $past(cp_wdata[15:12]) && (desc_offset_words < 0) == ($past(cp_wdata[16]) &&
			$past(cp_wdata[15:12]) != 4'h0);
	endproperty
	a_desc_offset: assert property (p_desc_offset) else $error("descriptor offset conversion wrong"); // RL8

	property p_param_write;
		@(posedge ref_clk) disable iff (!rstn)
		cp_valid && cp_priv && cp_write && hit_param |=> bounds_bit_position == $past(cp_wdata[21:17]) &&
			object_field_offset == $past(cp_wdata[3:0]) && static_value_offset == $past(cp_wdata[7:4]);
	endproperty
	a_param_write: assert property (p_param_write) else $error("parameter word not stored"); // RL12

	property p_bad_op;
		@(posedge ref_clk) disable iff (!rstn)
		cp_valid && cp_priv && cp_write && hit_xlat && cp_wdata[XLAT_OP_LSB +: 4] > OP_MAX |=> cp_undef && !cp_ack;
	endproperty
	a_bad_op: assert property (p_bad_op) else $error("illegal operation code accepted"); // RL15

	property p_lookup_range;
		@(posedge ref_clk) disable iff (!rstn)
		lookup_valid && (lookup_bytecode < XLAT_FIRST || lookup_bytecode > XLAT_LAST) |=> lookup_done && !lookup_hit;
	endproperty
	a_lookup_range: assert property (p_lookup_range) else $error("non-configurable bytecode translated"); // RL13
endmodule

`default_nettype wire

/* File: bca_xlat_table.sv */
// constants package and the configurable bytecode translation table
//
// Function
// RL1: index-width bit selects 8 or 16-bit indices
// RL2: static mode bit selects handles or pointers
// RL3: disabled: plain branch, status flag raises exception
// RL4: enabled: branch or flag enters bytecode state
// RL5: main word on opcode1 7, c2, c0, 0
// RL6: unprivileged access to these registers is refused
// RL7: bits 21:17 locate element count in descriptor
// RL8: bits 16:12 sign-magnitude descriptor word offset
// RL9: bits 11:8 array data word offset
// RL10: bits 7:4 static value word offset
// RL11: bits 3:0 object field word offset
// RL12: parameter word on opcode1 7, c3, c0, 0
// RL13: entry maps bytecodes 0xCB..0xFD onto operations
// RL14: opcode field holds low bytecode bits
// RL15: operation field holds codes zero to nine
// RL16: software writes reserved bits zero, reads zero
`timescale 1ns/1ps
`default_nettype none

package bca_pkg;
	// coprocessor selector fields
	localparam logic [2:0] CP_OPC1 = 3'h7;
	localparam logic [3:0] CRN_MAIN = 4'h2;
	localparam logic [3:0] CRN_PARAM = 4'h3;
	localparam logic [3:0] CRN_XLAT = 4'h4;
	localparam logic [3:0] CP_CRM = 4'h0;
	localparam logic [2:0] CP_OPC2 = 3'h0;
	// main configuration word layout
	localparam int IDX_WIDTH_BIT = 27;
	localparam int STATIC_PTR_BIT = 26;
	localparam int ENABLE_BIT = 0;
	localparam logic [31:0] MAIN_MASK = 32'h0C00_0001;
	localparam logic [31:0] MAIN_RESET = 32'h0000_0000;
	// parameter word layout
	localparam int BOUNDS_POS_LSB = 17;
	localparam int DESC_OFF_SIGN_BIT = 16;
	localparam int DESC_OFF_LSB = 12;
	localparam int DATA_OFF_LSB = 8;
	localparam int STATIC_OFF_LSB = 4;
	localparam int FIELD_OFF_LSB = 0;
	localparam logic [31:0] PARAM_MASK = 32'h003F_FFFF;
	localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
	// translation entry layout
	localparam int XLAT_CODE_LSB = 10;
	localparam int XLAT_OP_LSB = 0;
	localparam logic [31:0] XLAT_MASK = 32'h0000_FC0F;
	localparam logic [31:0] XLAT_RESET = 32'h0000_0000;
	localparam logic [7:0] XLAT_FIRST = 8'hCB;
	localparam logic [7:0] XLAT_LAST = 8'hFD;
	localparam logic [3:0] OP_MAX = 4'h9;

	// true when a transfer addresses the register at the given crn
	function automatic logic cp_sel(input logic [2:0] opc1, input logic [3:0] crn,
		input logic [3:0] crm, input logic [2:0] opc2, input logic [3:0] target);
		cp_sel = (opc1 == CP_OPC1) && (crn == target) && (crm == CP_CRM) && (opc2 == CP_OPC2);
	endfunction

	// low six bits must belong to a configurable bytecode
	function automatic logic code_ok(input logic [5:0] code);
		code_ok = (code >= XLAT_FIRST[5:0]) && (code <= XLAT_LAST[5:0]);
	endfunction
endpackage

module bca_xlat_table (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// write side
	input wire logic wr_en,
	input wire logic [5:0] wr_code,
	input wire logic [3:0] wr_op,
	// lookup side, combinational answer
	input wire logic [7:0] rd_bytecode,
	output logic rd_hit,
	output logic [3:0] rd_op
);
	import bca_pkg::*;

	typedef struct packed {
		logic [63:0][3:0] ops;
		logic [63:0] valid;
	} bca_tbl_s;

	bca_tbl_s st;
	bca_tbl_s next_st;

	// one slot per low-bit code; an unwritten slot never hits
	always_comb begin
		next_st = st;
		if (wr_en) begin
			next_st.ops[wr_code] = wr_op; // RL14
			next_st.valid[wr_code] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// only bytecodes in the configurable range may translate
	assign rd_hit = (rd_bytecode >= XLAT_FIRST) && (rd_bytecode <= XLAT_LAST) && st.valid[rd_bytecode[5:0]]; // RL13
	assign rd_op = st.ops[rd_bytecode[5:0]];
endmodule

`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the bytecode accelerator configuration registers
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import bca_pkg::*;
	// ****************
	// signals
	// ****************
	logic ref_clk = 0, rstn = 0, cp_valid = 0, cp_write = 0, cp_priv = 0;
	logic [2:0] cp_opc1 = 3'h7, cp_opc2 = 3'h0;
	logic [3:0] cp_crn = 4'h0, cp_crm = 4'h0;
	logic [31:0] cp_wdata = 32'h0000_0000, cp_rdata;
	logic cp_ack, cp_undef, enter_bytecode, plain_branch_exchange, accel_disabled_exc;
	logic branch_to_bytecode = 0, psw_bytecode_set = 0, lookup_valid = 0, lookup_done, lookup_hit;
	logic field_index_width, static_ref_pointer_mode, accel_enable;
	logic [4:0] bounds_bit_position, array_descriptor_offset_signed;
	logic signed [4:0] desc_offset_words;
	logic [3:0] array_data_word_offset, static_value_offset, object_field_offset, lookup_op;
	logic [7:0] lookup_bytecode = 8'h00;
	int err_total = 0, checks = 0;

	bca_config_regs i_dut (.ref_clk, .rstn, .cp_valid, .cp_write, .cp_priv, .cp_opc1, .cp_crn,
		.cp_crm, .cp_opc2, .cp_wdata, .cp_ack, .cp_undef, .cp_rdata, .branch_to_bytecode, .psw_bytecode_set,
		.enter_bytecode, .plain_branch_exchange, .accel_disabled_exc, .field_index_width,
		.static_ref_pointer_mode, .accel_enable, .bounds_bit_position, .array_descriptor_offset_signed,
		.desc_offset_words, .array_data_word_offset, .static_value_offset, .object_field_offset,
		.lookup_valid, .lookup_bytecode, .lookup_done, .lookup_hit, .lookup_op);

	// 250 MHz clock
	initial forever #2 ref_clk = ~ref_clk;

	// ****************
	// shared tasks
	// ****************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one transfer; the answer is registered, so it is judged one edge after the request
	task automatic cp(input logic wr, input logic pv, input logic [3:0] crn, input logic [31:0] wd,
		input logic ok, input logic [31:0] rd);
		@(posedge ref_clk);
		cp_valid <= 1'b1;
		cp_write <= wr;
		cp_priv <= pv;
		cp_crn <= crn;
		cp_wdata <= wd;
		@(posedge ref_clk);
		cp_valid <= 1'b0;
		#1;
		chk("cp_ack", ok, cp_ack);
		chk("cp_undef", !ok, cp_undef);
		if (ok && !wr)
			chk("cp_rdata", rd, cp_rdata);
	endtask

	// selector fields change on an edge, with no transfer pending
	task automatic sel(input logic [2:0] o1, input logic [3:0] m, input logic [2:0] o2);
		@(posedge ref_clk);
		cp_opc1 <= o1;
		cp_crm <= m;
		cp_opc2 <= o2;
	endtask

	task automatic ev(input logic br, input logic fl, input logic ent, input logic pl, input logic ex);
		@(posedge ref_clk);
		branch_to_bytecode <= br;
		psw_bytecode_set <= fl;
		@(posedge ref_clk);
		branch_to_bytecode <= 1'b0;
		psw_bytecode_set <= 1'b0;
		#1;
		chk("enter_bytecode", ent, enter_bytecode);
		chk("plain_branch_exchange", pl, plain_branch_exchange);
		chk("accel_disabled_exc", ex, accel_disabled_exc);
	endtask

	task automatic lk(input logic [7:0] code, input logic hit, input logic [3:0] op);
		@(posedge ref_clk);
		lookup_valid <= 1'b1;
		lookup_bytecode <= code;
		@(posedge ref_clk);
		lookup_valid <= 1'b0;
		#1;
		chk("lookup_done", 1'b1, lookup_done);
		chk("lookup_hit", hit, lookup_hit);
		if (hit)
			chk("lookup_op", op, lookup_op);
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic t_main();
		cp(1, 1, 4'h2, 32'h0C00_0001, 1, 0);
		cp(0, 1, 4'h2, 0, 1, 32'h0C00_0001);
		chk("field_index_width", 1'b1, field_index_width);
		chk("static_ref_pointer_mode", 1'b1, static_ref_pointer_mode);
		cp(1, 1, 4'h2, 32'h0800_0000, 1, 0);
		chk("static_ref_pointer_mode", 1'b0, static_ref_pointer_mode);
		chk("accel_enable", 1'b0, accel_enable);
		cp(1, 1, 4'h2, 32'h0400_0000, 1, 0);
		chk("field_index_width", 1'b0, field_index_width);
	endtask

	// disabled then enabled, each event kind alone and then both together
	task automatic t_events();
		cp(1, 1, 4'h2, 32'h0000_0000, 1, 0);
		ev(1, 0, 0, 1, 0);
		ev(0, 1, 0, 0, 1);
		ev(1, 1, 0, 1, 1);
		cp(1, 1, 4'h2, 32'h0000_0001, 1, 0);
		ev(1, 0, 1, 0, 0);
		ev(0, 1, 1, 0, 0);
		ev(1, 1, 1, 0, 0);
	endtask

	// negative, negative zero and positive descriptor offsets
	task automatic t_params();
		logic [31:0] v[3];
		logic [31:0] m;
		logic signed [4:0] d;
		v = '{32'h0029_D6C3, 32'h0001_0000, 32'h000A_7321};
		for (int i = 0; i < 3; i++) begin
			m = v[i] & 32'h003F_FFFF;
			d = m[16] ? -$signed({1'b0, m[15:12]}) : $signed({1'b0, m[15:12]});
			cp(1, 1, 4'h3, v[i], 1, 0);
			cp(0, 1, 4'h3, 0, 1, m);
			chk("bounds_bit_position", m[21:17], bounds_bit_position);
			chk("array_descriptor_offset_signed", m[16:12], array_descriptor_offset_signed);
			chk("desc_offset_words", d, desc_offset_words);
			chk("array_data_word_offset", m[11:8], array_data_word_offset);
			chk("static_value_offset", m[7:4], static_value_offset);
			chk("object_field_offset", m[3:0], object_field_offset);
		end
	endtask

	// unprivileged and mis-selected transfers are refused and change nothing
	task automatic t_priv();
		cp(1, 0, 4'h2, 32'h0000_0000, 0, 0);
		chk("accel_enable", 1'b1, accel_enable);
		cp(0, 0, 4'h3, 0, 0, 0);
		cp(1, 0, 4'h4, 32'h0000_2C05, 0, 0);
		cp(0, 1, 4'h5, 0, 0, 0);
		sel(3'h6, 4'h0, 3'h0);
		cp(0, 1, 4'h2, 0, 0, 0);
		sel(3'h7, 4'h1, 3'h0);
		cp(0, 1, 4'h2, 0, 0, 0);
		sel(3'h7, 4'h0, 3'h1);
		cp(0, 1, 4'h3, 0, 0, 0);
		sel(3'h7, 4'h0, 3'h0);
	endtask

	// a mid-run reset clears the words and empties the table
	task automatic t_reset();
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		cp(0, 1, 4'h2, 0, 1, 0);
		chk("accel_enable", 1'b0, accel_enable);
		lk(8'hCB, 0, 0);
	endtask

	task automatic t_xlat();
		lk(8'hCC, 0, 0);
		cp(1, 1, 4'h4, 32'h0000_2C05, 1, 0);
		cp(0, 1, 4'h4, 0, 1, 32'h0000_2C05);
		cp(1, 1, 4'h4, 32'h0000_F409, 1, 0);
		cp(0, 1, 4'h4, 0, 1, 32'h0000_F409);
		lk(8'hCB, 1, 4'h5);
		lk(8'hFD, 1, 4'h9);
		lk(8'hCA, 0, 0);
		lk(8'hFE, 0, 0);
		lk(8'h8B, 0, 0);
		cp(1, 1, 4'h4, 32'h0000_2C0A, 0, 0);
		cp(1, 1, 4'h4, 32'h0000_2805, 0, 0);
		lk(8'hCB, 1, 4'h5);
	endtask

	// ****************
	// run control
	// ****************
	task automatic results();
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// a hung run still reaches the verdict, counted as a mismatch
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		$display("[ERR] run_time expected finish seen timeout");
		results();
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		cp(0, 1, 4'h2, 0, 1, 0);
		cp(0, 1, 4'h3, 0, 1, 0);
		cp(0, 1, 4'h4, 0, 1, 0);
		t_main();
		t_events();
		t_params();
		t_priv();
		t_xlat();
		t_reset();
		results();
	end
endmodule

`default_nettype wire
